//--- rtl/buck_fault_hiccup_controller.sv
// holds the protection sequencer of the buck regulator
// assumes comparator flags are asynchronous and the oscillator pulse is one mclk wide after sync
`timescale 1ns/1ns
module buck_fault_hiccup_controller
    import hiccup_pkg::*;
#(
    parameter int OC_LIMIT    = OVERCURRENT_COUNT_LIMIT,
    parameter int OPEN_LIMIT  = BOOT_OPEN_CYCLES,
    parameter int SHORT_LIMIT = BOOT_SHORT_CYCLES,
    parameter int BLANK       = BLANK_CYCLES
) (
    input  wire logic   mclk,       // system clock
    input  wire logic   rst_n,      // async reset, active low
    input  wire logic   enable,     // converter enable level
    input  wire sense_t senseRaw,   // raw comparator indications
    output drive_t      drive,      // switch and node controls
    output logic        ocCountBusy // overcurrent counter nonzero
);
    localparam int OCW = $clog2(OC_LIMIT + 1);
    localparam int BOW = $clog2(OPEN_LIMIT + 1);
    localparam int BSW = $clog2(SHORT_LIMIT + 1);
    localparam int BLW = $clog2(BLANK + 1);

    initial begin
        if (OC_LIMIT < 1 || OPEN_LIMIT < 1 || SHORT_LIMIT < 1 || BLANK < 1)
            $error("limits must be at least one");
    end

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    sense_t sense;
    logic   enSync;
    logic [$bits(sense_t):0] syncAll;

    sync_bank #(.WIDTH($bits(sense_t) + 1)) u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .asyncIn ({enable, senseRaw}),
        .syncOut (syncAll)
    );
    assign enSync = syncAll[$bits(sense_t)];
    assign sense  = sense_t'(syncAll[$bits(sense_t)-1:0]);

    // ----------------------------------------------------------------
    // edge detection and switching flip-flop
    // ----------------------------------------------------------------
    logic           oscPrev_r, oscPrev_nxt;
    logic           ocPrev_r, ocPrev_nxt;
    logic           pwmOn_r, pwmOn_nxt;
    logic [BLW-1:0] blank_r, blank_nxt;
    logic           oscEdge, ocEdge, peakSeen, runAllowed;
    fault_state_t   state_r, state_nxt;

    // one-cycle event edges
    always_comb begin
        oscEdge = sense.oscPulse && !oscPrev_r;
        peakSeen = sense.peakCurrent && (blank_r == '0);  // RL3
        ocEdge  = peakSeen && !ocPrev_r;
        oscPrev_nxt = sense.oscPulse;
        ocPrev_nxt  = peakSeen;
    end

    // switching permitted only when no fault blocks it
    assign runAllowed = enSync && (state_r == ST_RUN) && !sense.overvoltage
                        && !sense.thermalTrip && sense.ssAboveRelease; // RL10 RL16 RL17 RL21

    // set by oscillator, reset dominant
    always_comb begin
        pwmOn_nxt = pwmOn_r;
        blank_nxt = blank_r;
        if (blank_r != '0)
            blank_nxt = blank_r - BLW'(1);
        if (oscEdge && !pwmOn_r) begin
            pwmOn_nxt = 1'b1;                                  // RL20 RL2
            blank_nxt = BLW'(BLANK);                           // RL3
        end
        if (!runAllowed || peakSeen || sense.pwmTrip) begin
            pwmOn_nxt = 1'b0;                                  // RL1 RL20
        end
        if (!runAllowed)
            blank_nxt = '0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscPrev_r <= 1'b0;
            ocPrev_r  <= 1'b0;
            pwmOn_r   <= 1'b0;
            blank_r   <= '0;
        end else begin
            oscPrev_r <= oscPrev_nxt;
            ocPrev_r  <= ocPrev_nxt;
            pwmOn_r   <= pwmOn_nxt;
            blank_r   <= blank_nxt;
        end
    end

    // ----------------------------------------------------------------
    // fault counters
    // ----------------------------------------------------------------
    logic [OCW-1:0] ocCnt_r, ocCnt_nxt;
    logic [BOW-1:0] openCnt_r, openCnt_nxt;
    logic [BSW-1:0] shortCnt_r, shortCnt_nxt;
    logic           ocHit, openHit, shortHit;

    always_comb begin
        ocCnt_nxt    = ocCnt_r;
        openCnt_nxt  = openCnt_r;
        shortCnt_nxt = shortCnt_r;
        if (!enSync || state_r != ST_RUN) begin
            ocCnt_nxt    = '0;                                 // RL22
            openCnt_nxt  = '0;
            shortCnt_nxt = '0;
        end else begin
            if (!sense.errorClampFlag)
                ocCnt_nxt = '0;                                // RL6
            else if (sense.ssAboveEnable && ocEdge && ocCnt_r < OCW'(OC_LIMIT))
                ocCnt_nxt = ocCnt_r + OCW'(1);                 // RL4 RL5 RL12
            if (!sense.bootOpen)
                openCnt_nxt = '0;                              // RL15
            else if (oscEdge && openCnt_r < BOW'(OPEN_LIMIT))
                openCnt_nxt = openCnt_r + BOW'(1);             // RL13
            if (!sense.bootShort)
                shortCnt_nxt = '0;                             // RL15
            else if (oscEdge && shortCnt_r < BSW'(SHORT_LIMIT))
                shortCnt_nxt = shortCnt_r + BSW'(1);           // RL14
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ocCnt_r    <= '0;
            openCnt_r  <= '0;
            shortCnt_r <= '0;
        end else begin
            ocCnt_r    <= ocCnt_nxt;
            openCnt_r  <= openCnt_nxt;
            shortCnt_r <= shortCnt_nxt;
        end
    end

    assign ocHit    = ocCnt_r    == OCW'(OC_LIMIT);            // RL7
    assign openHit  = openCnt_r  == BOW'(OPEN_LIMIT);          // RL13
    assign shortHit = shortCnt_r == BSW'(SHORT_LIMIT);         // RL14

    // ----------------------------------------------------------------
    // hiccup and thermal sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (sense.thermalTrip)
                    state_nxt = ST_THERMAL;                    // RL18
                else if (enSync && (ocHit || openHit || shortHit))
                    state_nxt = ST_HICCUP;                     // RL7 RL12 RL15
            end
            ST_HICCUP: begin
                if (!enSync)
                    state_nxt = ST_RUN;                        // RL22 RL11
                else if (sense.thermalTrip)
                    state_nxt = ST_THERMAL;
                else if (sense.ssBelowReset)
                    state_nxt = ST_RUN;                        // RL9 RL11
            end
            ST_THERMAL: begin
                if (!sense.thermalTrip && sense.ssBelowReset)
                    state_nxt = ST_RUN;                        // RL19
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // ----------------------------------------------------------------
    // output drive
    // ----------------------------------------------------------------
    drive_t drive_r, drive_nxt;

    always_comb begin
        drive_nxt.upperOn         = pwmOn_nxt;                 // RL1 RL21
        drive_nxt.lowerOn         = runAllowed && !pwmOn_nxt;  // RL16 RL21
        drive_nxt.hiccupSinkOn    = (state_nxt == ST_HICCUP);  // RL8
        drive_nxt.compPullDown    = (state_nxt == ST_HICCUP)
                                    || (state_nxt == ST_THERMAL); // RL7 RL18
        drive_nxt.ssPullDown      = (state_nxt == ST_THERMAL)
                                    || (!enSync && !sense.ssBelowReset); // RL18
        drive_nxt.startupSourceOn = enSync && (state_nxt == ST_RUN)
                                    && !sense.thermalTrip;     // RL9
        drive_nxt.powerGoodLowOe  = sense.overvoltage || sense.thermalTrip
                                    || (state_nxt == ST_THERMAL); // RL16 RL18
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            drive_r <= '0;
        else
            drive_r <= drive_nxt;
    end

    assign drive       = drive_r;
    assign ocCountBusy = (ocCnt_r != '0);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_hiccupEntry;
        state_r == ST_RUN && enSync && ocHit && !sense.thermalTrip;
    endsequence

    // latch set and both hiccup controls already driven
    sequence s_hiccupActive;
        state_r == ST_HICCUP && drive.compPullDown && drive.hiccupSinkOn;
    endsequence

    chk_upper_peak_off: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
        peakSeen |=> !pwmOn_r)
        else $error("upper switch stayed on after peak trip");

    chk_restart_on_osc: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
        (!pwmOn_r && !(oscEdge)) |=> !pwmOn_r)
        else $error("switch turned on without oscillator pulse");

    chk_blank_mask: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
        (blank_r != '0 && pwmOn_r && runAllowed && !sense.pwmTrip) |=> pwmOn_r)
        else $error("peak current not blanked");

    chk_oc_hold_low: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
        (!sense.ssAboveEnable && state_r == ST_RUN && enSync) |=> ocCnt_r <= $past(ocCnt_r))
        else $error("counter counted below enable level");

    chk_oc_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
        !sense.errorClampFlag |=> ocCnt_r == '0)
        else $error("counter not cleared when clamp dropped");

    chk_hiccup_set: assert property (@(posedge mclk) disable iff (!rst_n) // RL7
        s_hiccupEntry |=> s_hiccupActive)
        else $error("hiccup not entered at counter limit");

    chk_hiccup_exit: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
        (state_r == ST_HICCUP && sense.ssBelowReset && !sense.thermalTrip)
        |=> state_r == ST_RUN)
        else $error("hiccup latch not cleared at reset level");

    chk_ov_off: assert property (@(posedge mclk) disable iff (!rst_n) // RL16
        sense.overvoltage |=> !drive.upperOn && !drive.lowerOn && drive.powerGoodLowOe)
        else $error("overvoltage did not stop switching");

    chk_disable_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RL22
        !enSync |=> ocCnt_r == '0 && openCnt_r == '0 && shortCnt_r == '0)
        else $error("disable did not clear counters");

    chk_thermal_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RL18
        (state_r == ST_THERMAL && !sense.ssBelowReset) |=> state_r == ST_THERMAL)
        else $error("thermal hold released early");

    chk_oc_count_step: assert property (@(posedge mclk) disable iff (!rst_n) // RL5
        (state_r == ST_RUN && enSync && sense.errorClampFlag && sense.ssAboveEnable && ocEdge && !ocHit)
        |=> ocCnt_r == $past(ocCnt_r) + 1'b1)
        else $error("counter missed a clamped overcurrent pulse");

    chk_sink_in_hiccup: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
        (state_r == ST_HICCUP) |-> drive.hiccupSinkOn && !drive.startupSourceOn)
        else $error("hiccup sink not enabled");

    chk_boot_open_entry: assert property (@(posedge mclk) disable iff (!rst_n) // RL13
        (state_r == ST_RUN && enSync && openHit && !sense.thermalTrip) |=> s_hiccupActive)
        else $error("bootstrap open did not enter hiccup");

    chk_boot_short_entry: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
        (state_r == ST_RUN && enSync && shortHit && !sense.thermalTrip) |=> s_hiccupActive)
        else $error("bootstrap short did not enter hiccup");

    chk_boot_unlatched: assert property (@(posedge mclk) disable iff (!rst_n) // RL15
        (!sense.bootOpen && !sense.bootShort) |=> openCnt_r == '0 && shortCnt_r == '0)
        else $error("bootstrap counter kept a cleared fault");

    chk_release_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
        !sense.ssAboveRelease |=> !pwmOn_r)
        else $error("switching before soft-start release");

    chk_hiccup_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RL11
        (state_r == ST_HICCUP && enSync && !sense.ssBelowReset && !sense.thermalTrip) |=> state_r == ST_HICCUP)
        else $error("hiccup left before reset level");

    chk_ov_unlatched: assert property (@(posedge mclk) disable iff (!rst_n) // RL17
        (state_r == ST_RUN && sense.overvoltage && !sense.thermalTrip && !ocHit && !openHit && !shortHit)
        |=> state_r == ST_RUN)
        else $error("overvoltage latched a fault state");

    chk_thermal_exit: assert property (@(posedge mclk) disable iff (!rst_n) // RL19
        (state_r == ST_THERMAL && !sense.thermalTrip && sense.ssBelowReset) |=> state_r == ST_RUN)
        else $error("thermal state did not release");

    chk_thermal_nodes: assert property (@(posedge mclk) disable iff (!rst_n) // RL18
        (state_r == ST_THERMAL) |-> drive.compPullDown && drive.ssPullDown && drive.powerGoodLowOe)
        else $error("thermal pull-downs not applied");

    chk_osc_set: assert property (@(posedge mclk) disable iff (!rst_n) // RL20
        (oscEdge && !pwmOn_r && runAllowed && !peakSeen && !sense.pwmTrip) |=> pwmOn_r)
        else $error("oscillator pulse did not set the switch");

    chk_blocked_off: assert property (@(posedge mclk) disable iff (!rst_n) // RL21
        !runAllowed |=> !drive.upperOn && !drive.lowerOn)
        else $error("switches driven while blocked");
endmodule // buck_fault_hiccup_controller

//--- rtl/hiccup_pkg.sv
// holds constants and carrier types for the buck fault hiccup controller
// assumes all comparator indications arrive asynchronously to mclk
//
// Operation
// (RL1) peak current trip turns the upper switch off for the rest of the cycle
// (RL2) after a current-limit trip, switching restarts only at the next oscillator pulse
// (RL3) peak current indication is masked for a blanking time after upper turn-on
// (RL4) overcurrent counter is held off while soft-start is below hiccup enable level
// (RL5) counter counts overcurrent pulses only above enable level with clamp flag set
// (RL6) clamp flag low clears the overcurrent counter
// (RL7) counter at limit sets hiccup latch and the fast compensation pull-down
// (RL8) hiccup latch enables the small soft-start sink current
// (RL9) soft-start below reset level clears latch, stops sink, starts source current
// (RL10) switching resumes once soft-start exceeds error amplifier by release offset
// (RL11) hiccup repeats while overload persists; stops when cleared or disabled
// (RL12) only overcurrent hiccup entry is gated by the enable level
// (RL13) bootstrap open seen for 7 cycles enters hiccup
// (RL14) bootstrap short seen for 64 cycles enters hiccup
// (RL15) bootstrap faults use same hiccup sequence and are not latched
// (RL16) overvoltage turns both switches off, stops switching, pulls power good low
// (RL17) overvoltage shutdown is not latched; resumes when indication clears
// (RL18) thermal trip stops switching, pulls power good low, holds nodes low until reset level
// (RL19) thermal shutdown is not latched; restarts through soft-start when cleared
// (RL20) oscillator pulse sets the switching flip-flop; reset dominates set
// (RL21) disabled or faulted, both power switches are held off
// (RL22) disable clears the counters and the hiccup latch
package hiccup_pkg;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam int OVERCURRENT_COUNT_LIMIT = 240;
    localparam int BOOT_OPEN_CYCLES        = 7;
    localparam int BOOT_SHORT_CYCLES       = 64;
    localparam int CLK_FREQ_HZ             = 10_000_000;
    localparam int BLANK_TIME_NS           = 200;
    localparam int BLANK_CYCLES_RAW        = (BLANK_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int BLANK_CYCLES            = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;
    localparam int SYNC_STAGES             = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_HICCUP = 1'b0;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic oscPulse;        // oscillator clock pulse
        logic peakCurrent;     // peak current above peak_current_threshold
        logic pwmTrip;         // pwm comparator reset request
        logic errorClampFlag;  // compensation clamped at maximum
        logic ssAboveEnable;   // soft-start above hiccup_enable_level
        logic ssBelowReset;    // soft-start below reset level
        logic ssAboveRelease;  // soft-start above error amp by release offset
        logic bootOpen;        // bootstrap overvoltage
        logic bootShort;       // bootstrap undervoltage
        logic overvoltage;     // feedback_node above overvoltage_threshold
        logic thermalTrip;     // die over temperature
    } sense_t;

    typedef struct packed {
        logic upperOn;         // upper switch gate
        logic lowerOn;         // lower switch gate
        logic hiccupSinkOn;    // hiccup_sink_current enable
        logic startupSourceOn; // startup_source_current enable
        logic compPullDown;    // fast compensation pull-down
        logic ssPullDown;      // soft-start hard pull-down
        logic powerGoodLowOe;  // power_good_out pull-down enable
    } drive_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HICCUP,
        ST_THERMAL
    } fault_state_t;

endpackage

//--- rtl/sync_bank.sv
// holds a bank of two-flop synchronisers
// assumes inputs are asynchronous levels
`timescale 1ns/1ns
module sync_bank
    import hiccup_pkg::*;
#(
    parameter int WIDTH = 11
) (
    input  wire logic             mclk,    // system clock
    input  wire logic             rst_n,   // async reset
    input  wire logic [WIDTH-1:0] asyncIn, // raw levels
    output logic      [WIDTH-1:0] syncOut  // synchronised levels
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    initial begin
        if (WIDTH < 1) $error("sync_bank width must be positive");
    end

    // two flops per bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule // sync_bank

//--- bench/buck_analog_model.sv
// holds a behavioural model of the comparators, oscillator and soft-start node
// assumes drive comes from the controller and fault levels from the bench
`timescale 1ns/1ns
module buck_analog_model
    import hiccup_pkg::*;
(
    input  wire logic       mclk,     // system clock
    input  wire logic       rst_n,    // async reset
    input  wire drive_t     drive,    // controller outputs
    input  wire logic       overload, // output short present
    input  wire logic       clamp,    // error amp clamped
    input  wire logic [3:0] faultIn,  // boot open, boot short, ov, thermal
    output sense_t          sense     // comparator levels
);
    logic [5:0] ssLvl;  // soft-start level
    logic [3:0] oscCnt; // oscillator divider
    logic [3:0] onCnt;  // upper on time
    logic       peak;   // peak current level

    // ----------------------------------------------------------------
    // node and oscillator state
    // ----------------------------------------------------------------
    // sink and source ramp one step per cycle; hard pull-down empties at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ssLvl  <= 6'h00;
            oscCnt <= 4'h0;
            onCnt  <= 4'h0;
            peak   <= 1'b0;
        end else begin
            oscCnt <= (oscCnt == 4'h9) ? 4'h0 : oscCnt + 4'h1;
            onCnt  <= drive.upperOn ? onCnt + 4'h1 : 4'h0;
            peak   <= overload && drive.upperOn;
            if (drive.ssPullDown)
                ssLvl <= 6'h00;
            else if (drive.hiccupSinkOn && ssLvl != 6'h00)
                ssLvl <= ssLvl - 6'h01;
            else if (drive.startupSourceOn && ssLvl != 6'h3F)
                ssLvl <= ssLvl + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // comparator outputs
    // ----------------------------------------------------------------
    always_comb begin
        sense.oscPulse       = (oscCnt == 4'h0);
        sense.peakCurrent    = peak;
        sense.pwmTrip        = (onCnt == 4'h6); // loop ends a normal pulse
        sense.errorClampFlag = clamp;
        sense.ssAboveEnable  = (ssLvl > 6'h28);
        sense.ssBelowReset   = (ssLvl < 6'h04);
        sense.ssAboveRelease = (ssLvl > 6'h08);
        sense.bootOpen       = faultIn[3];
        sense.bootShort      = faultIn[2];
        sense.overvoltage    = faultIn[1];
        sense.thermalTrip    = faultIn[0];
    end
endmodule // buck_analog_model

//--- bench/buck_fault_hiccup_controller_tb.sv
// holds the self-checking bench of the fault hiccup controller
// assumes the analog model closes the loop on the controller outputs
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin numErrors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
`define WAIT(c, n) begin for (int k = 0; k < (n) && !(c); k++) step(1); end
module buck_fault_hiccup_controller_tb;
    import hiccup_pkg::*;
    logic       mclk;        // system clock
    logic       rst_n;       // async reset
    logic       enable;      // converter enable
    logic       overload;    // output short
    logic       clamp;       // error amp clamp
    logic [3:0] faultIn;     // other fault levels
    sense_t     senseRaw;    // comparator levels
    drive_t     drive;       // controller outputs
    logic       ocCountBusy; // counter nonzero
    int         numErrors;   // mismatches
    int         compares;    // comparisons
    int         cycles;      // timeout counter

    buck_fault_hiccup_controller #(.OC_LIMIT(4), .OPEN_LIMIT(3), .SHORT_LIMIT(5), .BLANK(1)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .enable(enable), .senseRaw(senseRaw),
        .drive(drive), .ocCountBusy(ocCountBusy));
    buck_analog_model u_model (
        .mclk(mclk), .rst_n(rst_n), .drive(drive), .overload(overload),
        .clamp(clamp), .faultIn(faultIn), .sense(senseRaw));

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // a hang counts as a mismatch and closes the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            finish_test();
        end
    end
    // samples just after the edge so outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic finish_test();
        if (numErrors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        enable = 1'b0;
        overload = 1'b0;
        clamp = 1'b0;
        faultIn = 4'h0;
        numErrors = 0;
        compares = 0;
        cycles = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        step(4);
        `CHK("idle switches", 2'b00, {drive.upperOn, drive.lowerOn})
        @(posedge mclk) enable <= 1'b1;
        `WAIT(drive.upperOn, 300)
        `CHK("startup switching", 1'b1, drive.upperOn)
        `CHK("power good", 1'b0, drive.powerGoodLowOe)
        step(60);
        // overload without clamp: pulse limiting but no counting
        @(posedge mclk) overload <= 1'b1;
        step(12);
        // a tripped pulse must end well before the loop's own end of pulse
        `WAIT(drive.upperOn, 20)
        for (int i = 0; i < 6 && drive.upperOn; i++) step(1);
        `CHK("peak trip off", 1'b0, drive.upperOn)
        step(3);
        `CHK("wait next osc", 1'b0, drive.upperOn)
        for (int i = 0; i < 100; i++) begin
            step(1);
            `CHK("no count unclamped", 2'b00, {ocCountBusy, drive.hiccupSinkOn})
        end
        // clamped overload: hiccup entry, ramp down, restart, repeat
        @(posedge mclk) clamp <= 1'b1;
        `WAIT(drive.hiccupSinkOn, 300)
        `CHK("hiccup sink", 1'b1, drive.hiccupSinkOn)
        `CHK("comp pull", 2'b10, {drive.compPullDown, drive.upperOn})
        `WAIT(drive.startupSourceOn, 300)
        `CHK("hiccup exit", 3'b100, {drive.startupSourceOn, drive.hiccupSinkOn, drive.compPullDown})
        `WAIT(drive.hiccupSinkOn, 400)
        `CHK("hiccup repeats", 1'b1, drive.hiccupSinkOn)
        @(posedge mclk) begin
            overload <= 1'b0;
            clamp    <= 1'b0;
        end
        `WAIT(drive.startupSourceOn, 300)
        step(150);
        `CHK("no more hiccup", 1'b0, drive.hiccupSinkOn)
        // bootstrap open, then short
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk) faultIn <= (i == 0) ? 4'h8 : 4'h4;
            `WAIT(drive.hiccupSinkOn, 400)
            `CHK("boot hiccup", 1'b1, drive.hiccupSinkOn)
            @(posedge mclk) faultIn <= 4'h0;
            `WAIT(drive.startupSourceOn, 300)
            `WAIT(drive.upperOn, 300)
            `CHK("boot recover", 1'b1, drive.upperOn)
        end
        // overvoltage stop and automatic resume
        @(posedge mclk) faultIn <= 4'h2;
        step(5);
        `CHK("ov stop", 3'b001, {drive.upperOn, drive.lowerOn, drive.powerGoodLowOe})
        @(posedge mclk) faultIn <= 4'h0;
        `WAIT(drive.upperOn, 100)
        `CHK("ov resume", 1'b1, drive.upperOn)
        // thermal stop with node pull-downs, then restart
        @(posedge mclk) faultIn <= 4'h1;
        step(5);
        `CHK("thermal stop", 4'b0111,
            {drive.upperOn, drive.compPullDown, drive.ssPullDown, drive.powerGoodLowOe})
        @(posedge mclk) faultIn <= 4'h0;
        `WAIT(drive.upperOn, 300)
        `CHK("thermal restart", 1'b1, drive.upperOn)
        // disable with a counter in progress
        @(posedge mclk) begin
            overload <= 1'b1;
            clamp    <= 1'b1;
        end
        `WAIT(ocCountBusy, 300)
        `CHK("count runs", 1'b1, ocCountBusy)
        @(posedge mclk) enable <= 1'b0;
        step(5);
        `CHK("disable clears", 4'b0000,
            {drive.upperOn, drive.lowerOn, ocCountBusy, drive.hiccupSinkOn})
        finish_test();
    end
endmodule // buck_fault_hiccup_controller_tb
